// >>> local_bus_pkg.sv
package local_bus_pkg;

  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] EVENT_OFF = 8'h08;
  localparam logic [6:0] CTRL_RESET = 7'h00;
  localparam logic [7:0] STRAP_RESET = 8'h00;

  // Wait states before the local bus termination, per access kind, and the register retry limit.
  localparam logic [2:0] RETRY_WAITS = 3'h1;
  localparam logic [2:0] BURST_WR_WAITS = 3'h1;
  localparam logic [2:0] POSTED_WR_WAITS = 3'h1;
  localparam logic [2:0] DELAYED_WAITS = 3'h2;
  localparam logic [2:0] DELAYED_BURST_WAITS = 3'h1;
  localparam logic [2:0] UNALIGNED_EXTRA = 3'h1;
  localparam logic [2:0] REG_RD_WAITS = 3'h2;
  localparam logic [2:0] REG_WR_WAITS = 3'h5;
  localparam logic [2:0] DMA_WAITS = 3'h1;
  localparam logic [1:0] REG_RETRY_MAX = 2'h2;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_WAIT = 2'b01,
    S_ACK = 2'b11
  } slave_state_t;

  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_REQ = 2'b01,
    M_OWN = 2'b11
  } master_state_t;

  typedef enum logic [1:0] {
    K_REG = 2'b00,
    K_WIN = 2'b01,
    K_DMA = 2'b10
  } access_kind_t;

  typedef struct packed {
    logic sw_reset;
    logic proc_mode;
    logic bus16;
    logic narrow_port_sel;
    logic fast_term;
    logic dual_addr;
    logic dma_enable;
  } ctrl_t;

  typedef struct packed {
    logic pci_arbiter_strap;
    logic pci_disable_strap;
    logic id_select_enable;
    logic master_enable_strap;
    logic [1:0] test_mode_sel;
    logic burst_in_progress_n;
    logic size1;
  } strap_t;

  typedef struct packed {
    logic post_en;
    logic fifo_room;
    logic delayed_ready;
    logic reg_busy;
  } path_t;

endpackage : local_bus_pkg

// >>> local_bus_port.sv
// The Wishbone interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Peripheral DMA transfers use their own timing, not the slave wait table.
// - A retried access gets exactly one wait state before the retry.
// - Burst writes from the processor get one wait state.
// - Posted single writes get one wait state before acknowledge.
// - Completed delayed single reads and writes get two wait states.
// - Completed delayed burst reads get one wait state.
// - Register accesses are retried at most twice before completing.
// - Register reads acknowledge three clocks after start, writes six.
// - Take bus mastership only after others release busy and grant acknowledge.
// - Window select negated for single-address DMA, asserted for dual; address ignored.
// - The local address bus is not examined during peripheral DMA.
// - First mode: size acks driven only in dual-address standard termination.
// - Low size ack unused for DMA on a 16-bit port.
// - Low size ack never asserted while narrow port select is off.
// - Dual-address DMA never ends with retry or bus error.
// - Unaligned bursts get at least one extra wait state.
// - Second mode: transfer start input in both DMA modes, window as first mode.
// - Straps latch on rising local or PCI reset and falling board ok.
// - Reset out follows PCI reset; software transitions timed from PCI clock.
// - With window select asserted, image select low picks image 0, high image 1.
module local_bus_port
  import local_bus_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic transfer_start_n,
  input wire logic address_strobe_n,
  input wire logic register_select_n,
  input wire logic bridge_window_select_n,
  input wire logic image_select,
  input wire logic read_write,
  input wire logic burst_n,
  input wire logic [3:0] local_addr_low,
  input wire local_bus_pkg::path_t path,
  output logic image_sel,
  output logic transfer_ack_n_o,
  output logic transfer_ack_oe_n,
  input wire logic transfer_ack_n_i,
  output logic retry_n_o,
  output logic retry_oe_n,
  output logic size_ack_high_n_o,
  output logic size_ack_high_oe_n,
  output logic size_ack_low_n_o,
  output logic size_ack_low_oe_n,
  input wire logic dma_ack_n,
  input wire logic dma_data_ready,
  output logic dma_request_n,
  input wire logic master_req,
  input wire logic master_done,
  input wire logic bus_grant_n,
  input wire logic grant_ack_n,
  input wire logic bus_busy_n_i,
  output logic bus_busy_n_o,
  output logic bus_busy_oe_n,
  output logic bus_request_n,
  output logic master_ack,
  input wire logic reset_in_n,
  input wire logic pci_rst_n,
  input wire logic pci_clk,
  input wire logic board_ok_n,
  input wire local_bus_pkg::strap_t strap_pins,
  output local_bus_pkg::strap_t strap_latched,
  output logic reset_out_n_o,
  output logic reset_out_oe_n
);
  import local_bus_pkg::*;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  ctrl_t ctrl_q;
  logic sel_err_q;
  slave_state_t state_q;
  access_kind_t kind_q;
  logic retry_q;
  logic write_q;
  logic [2:0] wait_q;
  logic [2:0] elapsed_q;
  logic [1:0] reg_retry_q;
  master_state_t mstate_q;
  logic reset_in_prev_q;
  logic pci_rst_prev_q;
  logic board_ok_prev_q;
  logic pci_clk_prev_q;
  logic sw_rst_pclk_q;
  logic wb_req;
  logic dma_cyc;
  logic reg_cyc;
  logic win_cyc;
  logic dma_window_ok;
  logic [3:0] plan;
  logic term_ok;

  // Returns {retry, waits} for an access through a bridge window.
  function automatic logic [3:0] window_plan(input logic wr, input logic burst, input logic unaligned,
                                             input path_t p);
    logic [2:0] extra;
    extra = unaligned ? UNALIGNED_EXTRA : 3'h0;
    if (wr && burst) begin
      window_plan = p.fifo_room ? {1'b0, 3'(BURST_WR_WAITS + extra)} : {1'b1, RETRY_WAITS};
    end else if (wr && p.post_en) begin
      window_plan = p.fifo_room ? {1'b0, POSTED_WR_WAITS} : {1'b1, RETRY_WAITS};
    end else if (burst) begin
      window_plan = p.delayed_ready ? {1'b0, 3'(DELAYED_BURST_WAITS + extra)} : {1'b1, RETRY_WAITS};
    end else begin
      window_plan = p.delayed_ready ? {1'b0, DELAYED_WAITS} : {1'b1, RETRY_WAITS};
    end
  endfunction : window_plan

  // Wishbone slave: answers every access one cycle after the strobe.
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        if (wb_adr_i == CTRL_OFF) begin
          wb_dat_o <= {25'h000_0000, ctrl_q};
        end else if (wb_adr_i == STATUS_OFF) begin
          wb_dat_o <= {16'h0000, sw_rst_pclk_q, 1'b0, mstate_q, reg_retry_q, state_q, strap_latched};
        end else if (wb_adr_i == EVENT_OFF) begin
          wb_dat_o <= {31'h0000_0000, sel_err_q};
        end else begin
          wb_dat_o <= 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
    end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == CTRL_OFF) begin
      ctrl_q <= wb_dat_i[6:0];
    end
  end

  // A DMA cycle whose window select disagrees with the mode is flagged; set wins over clear.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_err_q <= 1'b0;
    end else if (state_q == S_IDLE && dma_cyc && !dma_window_ok) begin
      sel_err_q <= 1'b1;
    end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == EVENT_OFF && wb_dat_i[0]) begin
      sel_err_q <= 1'b0;
    end
  end

  // The DMA qualifiers look at strobes and selects only, never at the address bus.
  assign dma_cyc = ctrl_q.dma_enable && !dma_ack_n
                   && (ctrl_q.proc_mode ? !transfer_start_n : !address_strobe_n);
  assign dma_window_ok = ctrl_q.dual_addr ? !bridge_window_select_n : bridge_window_select_n;
  assign reg_cyc = !transfer_start_n && !register_select_n;
  assign win_cyc = !transfer_start_n && !bridge_window_select_n;
  assign plan = window_plan(!read_write, !burst_n, local_addr_low != 4'h0, path);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
      kind_q <= K_REG;
      retry_q <= 1'b0;
      write_q <= 1'b0;
      wait_q <= 3'h0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (dma_cyc) begin
            if (dma_window_ok) begin
              state_q <= S_WAIT;
              kind_q <= K_DMA;
              retry_q <= 1'b0;
              write_q <= !read_write;
              wait_q <= DMA_WAITS;
            end
          end else if (reg_cyc) begin
            state_q <= S_WAIT;
            kind_q <= K_REG;
            write_q <= !read_write;
            if (path.reg_busy && reg_retry_q < REG_RETRY_MAX) begin
              retry_q <= 1'b1;
              wait_q <= RETRY_WAITS;
            end else begin
              retry_q <= 1'b0;
              wait_q <= read_write ? REG_RD_WAITS : REG_WR_WAITS;
            end
          end else if (win_cyc) begin
            state_q <= S_WAIT;
            kind_q <= K_WIN;
            write_q <= !read_write;
            retry_q <= plan[3];
            wait_q <= plan[2:0];
          end
        end
        S_WAIT: begin
          if (wait_q <= 3'h1) begin
            state_q <= S_ACK;
          end else begin
            wait_q <= wait_q - 3'h1;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // Counts clocks since transfer start so that the ack clock can be checked.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      elapsed_q <= 3'h0;
    end else if (state_q == S_IDLE) begin
      elapsed_q <= 3'h1;
    end else if (elapsed_q != 3'h7) begin
      elapsed_q <= elapsed_q + 3'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_retry_q <= 2'h0;
    end else if (state_q == S_ACK && kind_q == K_REG) begin
      reg_retry_q <= retry_q ? reg_retry_q + 2'h1 : 2'h0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      image_sel <= 1'b0;
    end else if (state_q == S_IDLE && win_cyc && !dma_cyc && !reg_cyc) begin
      image_sel <= image_select;
    end
  end

  // Single-address DMA is ended by the far side; the device ends dual-address cycles only, in first mode only without fast termination.
  assign term_ok = state_q == S_ACK && !retry_q
                   && (kind_q != K_DMA || (ctrl_q.dual_addr && (ctrl_q.proc_mode || !ctrl_q.fast_term)));
  assign transfer_ack_n_o = 1'b0;
  assign transfer_ack_oe_n = !(term_ok && ctrl_q.proc_mode);
  assign size_ack_high_n_o = 1'b0;
  assign size_ack_high_oe_n = !(term_ok && !ctrl_q.proc_mode);
  assign size_ack_low_n_o = 1'b0;
  assign size_ack_low_oe_n = !(term_ok && !ctrl_q.proc_mode && ctrl_q.narrow_port_sel && !ctrl_q.bus16);
  assign retry_n_o = 1'b0;
  assign retry_oe_n = !(state_q == S_ACK && retry_q && kind_q != K_DMA);
  assign dma_request_n = !(ctrl_q.dma_enable && dma_data_ready);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mstate_q <= M_IDLE;
    end else begin
      case (mstate_q)
        M_IDLE: begin
          if (master_req) begin
            mstate_q <= M_REQ;
          end
        end
        M_REQ: begin
          if (!bus_grant_n && bus_busy_n_i && grant_ack_n) begin
            mstate_q <= M_OWN;
          end
        end
        default: begin
          if (master_done) begin
            mstate_q <= M_IDLE;
          end
        end
      endcase
    end
  end

  assign bus_request_n = mstate_q != M_REQ;
  assign bus_busy_n_o = 1'b0;
  assign bus_busy_oe_n = mstate_q != M_OWN;
  assign master_ack = mstate_q == M_OWN && !transfer_ack_n_i;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reset_in_prev_q <= 1'b0;
      pci_rst_prev_q <= 1'b0;
      board_ok_prev_q <= 1'b0;
      pci_clk_prev_q <= 1'b0;
    end else begin
      reset_in_prev_q <= reset_in_n;
      pci_rst_prev_q <= pci_rst_n;
      board_ok_prev_q <= board_ok_n;
      pci_clk_prev_q <= pci_clk;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_latched <= STRAP_RESET;
    end else if ((reset_in_n && !reset_in_prev_q) || (pci_rst_n && !pci_rst_prev_q)
                 || (!board_ok_n && board_ok_prev_q)) begin
      strap_latched <= strap_pins;
    end
  end

  // The software reset request only moves on a rising PCI clock edge.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_rst_pclk_q <= 1'b0;
    end else if (pci_clk && !pci_clk_prev_q) begin
      sw_rst_pclk_q <= ctrl_q.sw_reset;
    end
  end

  assign reset_out_n_o = 1'b0;
  assign reset_out_oe_n = pci_rst_n && !sw_rst_pclk_q;

  a_reg_read_time: assert property (state_q == S_ACK && kind_q == K_REG && !retry_q && !write_q
                                    |-> elapsed_q == 3'h3 && !(transfer_ack_oe_n && size_ack_high_oe_n))
    else $error("register read not acknowledged three clocks after start");
  a_reg_write_time: assert property (state_q == S_ACK && kind_q == K_REG && !retry_q && write_q
                                     |-> elapsed_q == 3'h6)
    else $error("register write not acknowledged six clocks after start");
  a_retry_one_wait: assert property (!retry_oe_n |-> elapsed_q == 3'h2)
    else $error("retry not given after exactly one wait state");
  a_reg_retry_max: assert property (reg_retry_q == REG_RETRY_MAX && state_q == S_IDLE
                                    && reg_cyc && !dma_cyc |=> !retry_q)
    else $error("register access retried more than twice");
  a_dma_no_retry: assert property (kind_q == K_DMA |-> retry_oe_n)
    else $error("retry given during a DMA cycle");
  a_low_ack_gated: assert property (!ctrl_q.narrow_port_sel || ctrl_q.bus16 |-> size_ack_low_oe_n)
    else $error("low size ack asserted while not allowed");
  a_master_waits: assert property ($rose(mstate_q == M_OWN)
                                   |-> $past(bus_busy_n_i) && $past(grant_ack_n))
    else $error("bus taken while another master held it");
  a_reset_follow: assert property (!pci_rst_n |-> !reset_out_oe_n)
    else $error("reset out not asserted during PCI reset");
  a_reset_release: assert property (pci_rst_n && !sw_rst_pclk_q |-> reset_out_oe_n)
    else $error("reset out not released after PCI reset");
  a_posted_one_wait: assert property (state_q == S_IDLE && win_cyc && !reg_cyc && !dma_cyc
                                      && !read_write && burst_n && path.post_en && path.fifo_room
                                      |-> ##2 (!transfer_ack_oe_n || !size_ack_high_oe_n))
    else $error("posted write not acknowledged after one wait state");

  c_reg_read: cover property (state_q == S_ACK && kind_q == K_REG && !write_q && !retry_q);
  c_retry: cover property (!retry_oe_n);
  c_dma_dual: cover property (term_ok && kind_q == K_DMA);
  c_master_own: cover property (master_ack);

endmodule : local_bus_port

`default_nettype wire

// >>> local_processor_model.sv
`timescale 1ns/1ps
`default_nettype none
module local_processor_model (
  input wire logic clk,
  input wire logic term_n,
  input wire logic retry_oe_n,
  output logic transfer_start_n,
  output logic address_strobe_n,
  output logic register_select_n,
  output logic bridge_window_select_n,
  output logic read_write,
  output logic burst_n,
  output logic [3:0] local_addr_low,
  output logic dma_ack_n
);
  initial begin
    {transfer_start_n, address_strobe_n, register_select_n, bridge_window_select_n, dma_ack_n} = 5'h1F;
    read_write = 1'b1;
    burst_n = 1'b1;
    local_addr_low = 4'h0;
  end
  // Start pulses for one cycle; selects hold until termination, then released lines flip.
  // The result n is the cycle index of the termination, or -1 when none came.
  task automatic access(input logic [2:0] sel_n, input logic rd, input logic bst, input logic [3:0] adr,
                        output int n, output logic rty);
    {register_select_n, bridge_window_select_n, address_strobe_n} <= sel_n;
    dma_ack_n <= sel_n[0];
    transfer_start_n <= 1'b0;
    read_write <= rd;
    burst_n <= !bst;
    local_addr_low <= adr;
    n = -1;
    rty = 1'b0;
    for (int i = 0; i < 12 && n < 0; i++) begin
      @(posedge clk);
      transfer_start_n <= 1'b1;
      if (term_n === 1'b0) begin
        n = i;
        rty = !retry_oe_n;
      end
    end
    {register_select_n, bridge_window_select_n, address_strobe_n, dma_ack_n} <= 4'hF;
    local_addr_low <= ~adr;
    read_write <= !rd;
  endtask : access
endmodule : local_processor_model
`default_nettype wire

// >>> local_bus_slave_dma_handshake_bench.sv
`timescale 1ns/1ps
`default_nettype none
module local_bus_slave_dma_handshake_bench;
  import local_bus_pkg::*;
  logic clk = 1'b0, rst = 1'b1, pci_clk = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic image_select = 1'b0, image_sel, low_seen = 1'b0;
  path_t path = 4'h0;
  strap_t strap_pins = 8'h00, strap_latched;
  logic transfer_ack_n_o, transfer_ack_oe_n, retry_n_o, retry_oe_n, size_ack_high_n_o, size_ack_high_oe_n;
  logic size_ack_low_n_o, size_ack_low_oe_n, dma_data_ready = 1'b0, dma_request_n;
  logic master_req = 1'b0, master_done = 1'b0, bus_grant_n = 1'b1, grant_ack_n = 1'b1;
  logic other_busy_n = 1'b1, slave_ta_n = 1'b1, bus_busy_n_o, bus_busy_oe_n, bus_request_n, master_ack;
  logic reset_in_n = 1'b1, pci_rst_n = 1'b1, board_ok_n = 1'b0, reset_out_n_o, reset_out_oe_n;
  logic transfer_start_n, address_strobe_n, register_select_n, bridge_window_select_n;
  logic read_write, burst_n, dma_ack_n;
  logic [3:0] local_addr_low;
  wire logic bb_wire = other_busy_n & (bus_busy_oe_n | bus_busy_n_o);
  wire logic ta_wire = slave_ta_n & (transfer_ack_oe_n | transfer_ack_n_o);
  wire logic term_n = (transfer_ack_oe_n | transfer_ack_n_o) & (size_ack_high_oe_n | size_ack_high_n_o)
                      & (size_ack_low_oe_n | size_ack_low_n_o) & (retry_oe_n | retry_n_o);
  int miscompares = 0, comparisons = 0;
  always #50 clk = ~clk;
  always #170 pci_clk = ~pci_clk;
  always @(posedge clk) if (size_ack_low_oe_n === 1'b0) low_seen <= 1'b1;

  local_bus_port local_bus_port_i (
    .clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .transfer_start_n, .address_strobe_n, .register_select_n, .bridge_window_select_n, .image_select,
    .read_write, .burst_n, .local_addr_low, .path, .image_sel, .transfer_ack_n_o, .transfer_ack_oe_n,
    .transfer_ack_n_i(ta_wire), .retry_n_o, .retry_oe_n, .size_ack_high_n_o, .size_ack_high_oe_n,
    .size_ack_low_n_o, .size_ack_low_oe_n, .dma_ack_n, .dma_data_ready, .dma_request_n, .master_req,
    .master_done, .bus_grant_n, .grant_ack_n, .bus_busy_n_i(bb_wire), .bus_busy_n_o, .bus_busy_oe_n,
    .bus_request_n, .master_ack, .reset_in_n, .pci_rst_n, .pci_clk, .board_ok_n, .strap_pins,
    .strap_latched, .reset_out_n_o, .reset_out_oe_n
  );
  local_processor_model local_processor_model_i (
    .clk, .term_n, .retry_oe_n, .transfer_start_n, .address_strobe_n, .register_select_n,
    .bridge_window_select_n, .read_write, .burst_n, .local_addr_low, .dma_ack_n
  );

  task automatic chk(input bit ok, input string m);
    comparisons++;
    if (!ok) begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic final_report();
    if (miscompares == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    chk(n < 20, "bus ack timeout");
    if (n >= 20) final_report();
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk);
  endtask : wb

  // Reference model: termination comes at cycle index waits + 1 of the access.
  function automatic int term_at(input int waits);
    return (waits < 0) ? -1 : waits + 1;
  endfunction : term_at

  task automatic slv(input logic [2:0] s, input logic rd, input logic bst, input logic [3:0] a,
                     input logic [3:0] p, input int waits, input logic exp_rty, input string m);
    int n;
    logic r;
    logic img;
    img = 1'($urandom);
    path <= p;
    image_select <= img;
    @(posedge clk);
    local_processor_model_i.access(s, rd, bst, a, n, r);
    chk(n == term_at(waits) && r === exp_rty, m);
    if (s == 3'b101) chk(image_sel === img, "image choice");
    @(posedge clk);
  endtask : slv

  initial begin
    logic [31:0] q;
    logic [31:0] d;
    void'($urandom(32'h7B6E));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wb(1'b0, CTRL_OFF, 32'h0, q);
    chk(q[6:0] === CTRL_RESET, "control reset value");
    wb(1'b1, 8'h0C, 32'hFFFFFFFF, q);
    wb(1'b0, 8'h0C, 32'h0, q);
    chk(q === 32'h0, "unmapped read");
    d = $urandom & 32'h3F;
    wb(1'b1, CTRL_OFF, d, q);
    wb(1'b0, CTRL_OFF, 32'h0, q);
    chk(q[6:0] === d[6:0], "control readback");
    wb(1'b1, CTRL_OFF, 32'h0, q);
    slv(3'b011, 1'b1, 1'b0, 4'h0, 4'b1100, 2, 1'b0, "register read");
    slv(3'b011, 1'b0, 1'b0, 4'h0, 4'b1100, 5, 1'b0, "register write");
    repeat (2) slv(3'b011, 1'b1, 1'b0, 4'h0, 4'b1101, 1, 1'b1, "register retry");
    slv(3'b011, 1'b1, 1'b0, 4'h0, 4'b1101, 2, 1'b0, "third try completes");
    slv(3'b101, 1'b0, 1'b0, 4'h0, 4'b1100, 1, 1'b0, "posted write");
    slv(3'b101, 1'b0, 1'b1, 4'h0, 4'b1100, 1, 1'b0, "burst write");
    slv(3'b101, 1'b0, 1'b1, 4'h4, 4'b1100, 2, 1'b0, "unaligned burst write");
    slv(3'b101, 1'b1, 1'b0, 4'h0, 4'b0110, 2, 1'b0, "delayed read");
    slv(3'b101, 1'b0, 1'b0, 4'h0, 4'b0110, 2, 1'b0, "delayed write");
    slv(3'b101, 1'b1, 1'b1, 4'h0, 4'b0110, 1, 1'b0, "delayed burst read");
    slv(3'b101, 1'b1, 1'b1, 4'h8, 4'b0110, 2, 1'b0, "unaligned burst read");
    slv(3'b101, 1'b0, 1'b0, 4'h0, 4'b1000, 1, 1'b1, "write retry");
    slv(3'b101, 1'b1, 1'b0, 4'h0, 4'b0100, 1, 1'b1, "read retry");
    wb(1'b1, CTRL_OFF, 32'h03, q);
    dma_data_ready <= 1'b1;
    low_seen <= 1'b0;
    repeat (2) @(posedge clk);
    chk(dma_request_n === 1'b0, "dma request");
    slv(3'b100, 1'b1, 1'b0, 4'($urandom), 4'b0000, 1, 1'b0, "dual dma");
    wb(1'b1, CTRL_OFF, 32'h1B, q);
    slv(3'b100, 1'b0, 1'b0, 4'($urandom), 4'b0000, 1, 1'b0, "narrow dma");
    chk(low_seen === 1'b0, "low size ack used");
    wb(1'b1, CTRL_OFF, 32'h0B, q);
    low_seen <= 1'b0;
    slv(3'b100, 1'b1, 1'b0, 4'h0, 4'b0000, 1, 1'b0, "narrow port dma");
    chk(low_seen === 1'b1, "low size ack missing");
    slv(3'b110, 1'b1, 1'b0, 4'h0, 4'b0000, -1, 1'b0, "dma without window");
    wb(1'b0, EVENT_OFF, 32'h0, q);
    chk(q[0] === 1'b1, "window mismatch flag");
    wb(1'b1, EVENT_OFF, 32'h1, q);
    wb(1'b0, EVENT_OFF, 32'h0, q);
    chk(q[0] === 1'b0, "flag clear");
    wb(1'b1, CTRL_OFF, 32'h23, q);
    slv(3'b100, 1'b1, 1'b0, 4'($urandom), 4'b0000, 1, 1'b0, "second mode dual dma");
    wb(1'b1, CTRL_OFF, 32'h07, q);
    slv(3'b100, 1'b0, 1'b0, 4'h0, 4'b0000, -1, 1'b0, "fast dual dma");
    wb(1'b1, CTRL_OFF, 32'h01, q);
    slv(3'b110, 1'b1, 1'b0, 4'h0, 4'b0000, -1, 1'b0, "single dma");
    wb(1'b0, EVENT_OFF, 32'h0, q);
    chk(q[0] === 1'b0, "single dma flagged");
    dma_data_ready <= 1'b0;
    master_req <= 1'b1;
    bus_grant_n <= 1'b0;
    other_busy_n <= 1'b0;
    grant_ack_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk(bus_busy_oe_n === 1'b1 && bus_request_n === 1'b0, "took busy bus");
    chk(dma_request_n === 1'b1, "dma request idle");
    other_busy_n <= 1'b1;
    grant_ack_n <= 1'b1;
    for (int i = 0; i < 8 && bus_busy_oe_n !== 1'b0; i++) @(posedge clk);
    chk(bus_busy_oe_n === 1'b0, "no ownership");
    slave_ta_n <= 1'b0;
    @(posedge clk);
    chk(master_ack === 1'b1, "zero wait ack");
    slave_ta_n <= 1'b1;
    master_done <= 1'b1;
    master_req <= 1'b0;
    repeat (3) @(posedge clk);
    master_done <= 1'b0;
    strap_pins <= 8'($urandom);
    reset_in_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_in_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk(strap_latched === strap_pins, "straps on reset in");
    wb(1'b0, STATUS_OFF, 32'h0, q);
    chk(q[7:0] === strap_pins, "strap status");
    board_ok_n <= 1'b1;
    repeat (3) @(posedge clk);
    strap_pins <= 8'($urandom);
    @(posedge clk);
    board_ok_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk(strap_latched === strap_pins, "straps on board ok");
    pci_rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    chk(reset_out_oe_n === 1'b0 && reset_out_n_o === 1'b0, "reset out on");
    pci_rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk(reset_out_oe_n === 1'b1, "reset out off");
    wb(1'b1, CTRL_OFF, 32'h40, q);
    for (int i = 0; i < 12 && reset_out_oe_n !== 1'b0; i++) @(posedge clk);
    chk(reset_out_oe_n === 1'b0, "software reset on");
    wb(1'b1, CTRL_OFF, 32'h00, q);
    for (int i = 0; i < 12 && reset_out_oe_n !== 1'b1; i++) @(posedge clk);
    chk(reset_out_oe_n === 1'b1, "software reset off");
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clk);
    chk(1'b0, "run timeout");
    final_report();
  end
endmodule : local_bus_slave_dma_handshake_bench
`default_nettype wire
